// [core/cop_clock_out.sv]
`default_nettype none
module cop_clock_out (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Register port.
    input wire cop_pkg::cop_bus_req_t bus_in,
    output logic [7:0] rdata_out,
    // Clock sources: oscillator ticks are enables on the system clock, timer clocks are levels that get synchronised.
    input wire logic main_osc_tick_in,
    input wire logic fast_osc_tick_in,
    input wire logic timer_a_clock_in,
    input wire logic timer_b_clock_in,
    // Shared pins.
    output cop_pkg::cop_pin_t shared_pin_a_out,
    output cop_pkg::cop_pin_t shared_pin_b_out
);
    logic [2:0] slow_ratio_q;
    logic [2:0] fast_ratio_q;
    logic slow_en_q;
    logic fast_en_q;
    logic tmr_a_en_q;
    logic tmr_b_en_q;
    logic [1:0] float_q;
    logic [1:0] level_q;
    logic [7:0] slow_cnt_q;
    logic [7:0] fast_cnt_q;
    logic [1:0] tmr_sync_a_q;
    logic [1:0] tmr_sync_b_q;
    logic slow_clk;
    logic fast_clk;
    logic pin_a_d;
    logic pin_b_d;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            slow_ratio_q <= cop_pkg::RATIO_RESET;
            fast_ratio_q <= cop_pkg::RATIO_RESET;
            slow_en_q <= 1'b0;
            fast_en_q <= 1'b0;
            tmr_a_en_q <= 1'b0;
            tmr_b_en_q <= 1'b0;
            float_q <= cop_pkg::FLOAT_RESET;
            level_q <= cop_pkg::LEVEL_RESET;
        end else if (bus_in.wr) begin
            case (bus_in.addr)
                cop_pkg::DIV_CTRL_ADDR: begin
                    slow_en_q <= bus_in.wdata[cop_pkg::SLOW_EN_BIT];
                    slow_ratio_q <=
                        bus_in.wdata[cop_pkg::SLOW_RATIO_LSB +: 3];
                    fast_en_q <= bus_in.wdata[cop_pkg::FAST_EN_BIT];
                    fast_ratio_q <=
                        bus_in.wdata[cop_pkg::FAST_RATIO_LSB +: 3];
                end
                cop_pkg::TMR_A_ADDR: begin
                    tmr_a_en_q <= bus_in.wdata[cop_pkg::TMR_EN_BIT];
                end
                cop_pkg::TMR_B_ADDR: begin
                    tmr_b_en_q <= bus_in.wdata[cop_pkg::TMR_EN_BIT];
                end
                cop_pkg::FLOAT_ADDR: begin
                    float_q <= bus_in.wdata[1:0];
                end
                cop_pkg::LEVEL_ADDR: begin
                    level_q <= bus_in.wdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    // Unmapped addresses and reserved bits read as zero.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                cop_pkg::DIV_CTRL_ADDR: begin
                    rdata_out <= {slow_en_q, slow_ratio_q,
                                  fast_en_q, fast_ratio_q};
                end
                cop_pkg::TMR_A_ADDR: begin
                    rdata_out <= {4'h0, tmr_a_en_q, 3'h0};
                end
                cop_pkg::TMR_B_ADDR: begin
                    rdata_out <= {4'h0, tmr_b_en_q, 3'h0};
                end
                cop_pkg::FLOAT_ADDR: begin
                    rdata_out <= {6'h00, float_q};
                end
                cop_pkg::LEVEL_ADDR: begin
                    rdata_out <= {6'h00, level_q};
                end
                default: begin
                    rdata_out <= 8'h00;
                end
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Dividers
    // ---------------------------------------------------------------
    // Each oscillator tick toggles a counter bit; bit n of a free count
    // runs at source over two^(n+1), so the tick itself gives ratio 1
    // when the oscillator tick is treated as one source half period.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            slow_cnt_q <= 8'h00;
        end else if (main_osc_tick_in) begin
            slow_cnt_q <= slow_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            fast_cnt_q <= 8'h00;
        end else if (fast_osc_tick_in) begin
            fast_cnt_q <= fast_cnt_q + 8'h01;
        end
    end

    // Code n picks bit n, a source half period stretched by two^n.
    assign slow_clk = slow_cnt_q[slow_ratio_q];
    assign fast_clk = fast_cnt_q[fast_ratio_q];

    // ---------------------------------------------------------------
    // Timer clock synchronisers
    // ---------------------------------------------------------------
    // Two flip-flops per timer clock; only the second one feeds the pins.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tmr_sync_a_q <= 2'h0;
            tmr_sync_b_q <= 2'h0;
        end else begin
            tmr_sync_a_q <= {tmr_sync_a_q[0], timer_a_clock_in};
            tmr_sync_b_q <= {tmr_sync_b_q[0], timer_b_clock_in};
        end
    end

    // ---------------------------------------------------------------
    // Pin selection
    // ---------------------------------------------------------------
    always_comb begin
        if (fast_en_q) begin
            pin_a_d = fast_clk;
        end else if (tmr_a_en_q) begin
            pin_a_d = tmr_sync_a_q[1];
        end else begin
            pin_a_d = 1'b1;
        end
        if (slow_en_q) begin
            pin_b_d = slow_clk;
        end else if (tmr_b_en_q) begin
            pin_b_d = tmr_sync_b_q[1];
        end else begin
            pin_b_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            shared_pin_a_out <= '{out: 1'b0, oe: 1'b0};
            shared_pin_b_out <= '{out: 1'b0, oe: 1'b0};
        end else begin
            shared_pin_a_out.oe <= ~float_q[cop_pkg::PIN_A_BIT];
            shared_pin_b_out.oe <= ~float_q[cop_pkg::PIN_B_BIT];
            shared_pin_a_out.out <=
                level_q[cop_pkg::PIN_A_BIT] & pin_a_d;
            shared_pin_b_out.out <=
                level_q[cop_pkg::PIN_B_BIT] & pin_b_d;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    float_drive_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $past(reset_in) == 1'b0 |-> shared_pin_a_out.oe ==
        ~$past(float_q[cop_pkg::PIN_A_BIT]))
        else $error("Pin a drive does not follow float bit.");

    float_drive_b_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $past(reset_in) == 1'b0 |-> shared_pin_b_out.oe ==
        ~$past(float_q[cop_pkg::PIN_B_BIT]))
        else $error("Pin b drive does not follow float bit.");

    reset_float_a: assert property (
        @(posedge clk_in)
        reset_in |=> float_q == cop_pkg::FLOAT_RESET &&
        level_q == cop_pkg::LEVEL_RESET)
        else $error("Pin bits wrong after reset.");

    reset_pins_a: assert property (
        @(posedge clk_in)
        reset_in |=> !shared_pin_a_out.oe && !shared_pin_b_out.oe)
        else $error("Pins driven right after reset.");

    level_low_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !level_q[cop_pkg::PIN_A_BIT] ##1 !reset_in |->
        !shared_pin_a_out.out)
        else $error("Pin a not low with level bit clear.");

    level_low_b_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !level_q[cop_pkg::PIN_B_BIT] ##1 !reset_in |->
        !shared_pin_b_out.out)
        else $error("Pin b not low with level bit clear.");

    reset_en_a: assert property (
        @(posedge clk_in)
        reset_in |=> !slow_en_q && !fast_en_q && !tmr_a_en_q
        && !tmr_b_en_q)
        else $error("Enables not cleared by reset.");

    reset_ratio_a: assert property (
        @(posedge clk_in)
        reset_in |=> slow_ratio_q == cop_pkg::RATIO_RESET &&
        fast_ratio_q == cop_pkg::RATIO_RESET)
        else $error("Ratios not cleared by reset.");

    ratio_write_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        bus_in.wr && bus_in.addr == cop_pkg::DIV_CTRL_ADDR |=>
        slow_ratio_q == $past(bus_in.wdata[cop_pkg::SLOW_RATIO_LSB +: 3]) &&
        fast_ratio_q == $past(bus_in.wdata[cop_pkg::FAST_RATIO_LSB +: 3]))
        else $error("Ratio write did not land.");

    enable_write_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        bus_in.wr && bus_in.addr == cop_pkg::DIV_CTRL_ADDR |=>
        slow_en_q == $past(bus_in.wdata[cop_pkg::SLOW_EN_BIT]) &&
        fast_en_q == $past(bus_in.wdata[cop_pkg::FAST_EN_BIT]))
        else $error("Divided enable write did not land.");

    timer_write_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        bus_in.wr && bus_in.addr == cop_pkg::TMR_A_ADDR |=>
        tmr_a_en_q == $past(bus_in.wdata[cop_pkg::TMR_EN_BIT]))
        else $error("Timer a enable write did not land.");

    timer_write_b_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        bus_in.wr && bus_in.addr == cop_pkg::TMR_B_ADDR |=>
        tmr_b_en_q == $past(bus_in.wdata[cop_pkg::TMR_EN_BIT]))
        else $error("Timer b enable write did not land.");

    read_ratio_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        bus_in.rd && bus_in.addr == cop_pkg::DIV_CTRL_ADDR |=>
        rdata_out == {$past(slow_en_q), $past(slow_ratio_q),
        $past(fast_en_q), $past(fast_ratio_q)})
        else $error("Divided clock control reads back wrong.");

    div_one_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        fast_ratio_q == 3'h0 && fast_osc_tick_in ##1 fast_ratio_q == 3'h0
        |-> fast_clk != $past(fast_clk))
        else $error("Undivided fast clock did not toggle.");

    slow_one_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        slow_ratio_q == 3'h0 && main_osc_tick_in ##1 slow_ratio_q == 3'h0
        |-> slow_clk != $past(slow_clk))
        else $error("Undivided slow clock did not toggle.");

    fast_pin_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        fast_en_q && level_q[cop_pkg::PIN_A_BIT] ##1 !reset_in |->
        shared_pin_a_out.out == $past(fast_clk))
        else $error("Fast clock missing on pin a.");

    slow_pin_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        slow_en_q && level_q[cop_pkg::PIN_B_BIT] ##1 !reset_in |->
        shared_pin_b_out.out == $past(slow_clk))
        else $error("Slow clock missing on pin b.");

    pin_a_idle_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !fast_en_q && !tmr_a_en_q && level_q[cop_pkg::PIN_A_BIT] ##1
        !reset_in |-> shared_pin_a_out.out)
        else $error("Idle pin a not high.");

    idle_high_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !slow_en_q && !tmr_b_en_q && level_q[cop_pkg::PIN_B_BIT] ##1
        !reset_in |-> shared_pin_b_out.out)
        else $error("Idle pin b not high.");

    timer_a_out_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !fast_en_q && tmr_a_en_q && level_q[cop_pkg::PIN_A_BIT] ##1
        !reset_in |-> shared_pin_a_out.out == $past(tmr_sync_a_q[1]))
        else $error("Timer clock missing on pin a.");

    timer_b_out_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !slow_en_q && tmr_b_en_q && level_q[cop_pkg::PIN_B_BIT] ##1
        !reset_in |-> shared_pin_b_out.out == $past(tmr_sync_b_q[1]))
        else $error("Timer clock missing on pin b.");

    cov_fast_c: cover property (@(posedge clk_in)
        fast_en_q && !float_q[0] && fast_ratio_q == 3'h7);
    cov_slow_c: cover property (@(posedge clk_in)
        slow_en_q && !float_q[1]);
    cov_timer_c: cover property (@(posedge clk_in)
        tmr_a_en_q && tmr_b_en_q);
    cov_both_c: cover property (@(posedge clk_in)
        fast_en_q && tmr_a_en_q);
    cov_level_c: cover property (@(posedge clk_in)
        !level_q[cop_pkg::PIN_B_BIT] && !float_q[cop_pkg::PIN_B_BIT]);
endmodule
`default_nettype wire

// [core/cop_pkg.sv]
// What this block does
// - Float bit 1 floats pin, 0 drives.
// - Reset sets both float bits to 1.
// - Level bit 0 holds pin low.
// - Reset sets both level bits to 1.
// - Bits 6..4 pick slow ratio, reset 0.
// - Bits 2..0 pick fast ratio, reset 0.
// - Ratio code n divides by two^n.
// - Bit 7 puts slow divided clock on pin b.
// - Bit 3 puts fast divided clock on pin a.
// - Reset clears both divided clock enables.
// - Timer a enable drives pin a unless bit 3 is set, else high.
// - Timer b enable drives pin b unless bit 7 is set, else high.
// - Reset clears both timer clock enables.
`default_nettype none
package cop_pkg;
    localparam logic [15:0] DIV_CTRL_ADDR = 16'hff14;
    localparam logic [15:0] TMR_A_ADDR = 16'hff30;
    localparam logic [15:0] TMR_B_ADDR = 16'hff31;
    localparam logic [15:0] FLOAT_ADDR = 16'hffd4;
    localparam logic [15:0] LEVEL_ADDR = 16'hffd9;
    localparam int SLOW_EN_BIT = 7;
    localparam int SLOW_RATIO_LSB = 4;
    localparam int FAST_EN_BIT = 3;
    localparam int FAST_RATIO_LSB = 0;
    localparam int TMR_EN_BIT = 3;
    localparam int PIN_A_BIT = 0;
    localparam int PIN_B_BIT = 1;
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam logic [1:0] FLOAT_RESET = 2'h3;
    localparam logic [1:0] LEVEL_RESET = 2'h3;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cop_bus_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } cop_pin_t;
endpackage
`default_nettype wire

// [sim/clock_output_port_control_test.sv]
`default_nettype none
module clock_output_port_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    cop_pkg::cop_bus_req_t bus_q = '0;
    logic [7:0] rdata;
    logic main_q = 1'b0;
    logic fast_q = 1'b1;
    logic tmr_a_q = 1'b0;
    logic tmr_b_q = 1'b0;
    logic clear_q = 1'b1;
    cop_pkg::cop_pin_t pin_a;
    cop_pkg::cop_pin_t pin_b;
    logic [15:0] ea;
    logic [15:0] eb;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        main_q <= cycles[0];
        tmr_a_q <= cycles[3];
        tmr_b_q <= cycles[2];
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    cop_clock_out i_cop_clock_out (.clk_in(clk_in), .reset_in(reset_in),
        .bus_in(bus_q), .rdata_out(rdata), .main_osc_tick_in(main_q),
        .fast_osc_tick_in(fast_q), .timer_a_clock_in(tmr_a_q),
        .timer_b_clock_in(tmr_b_q), .shared_pin_a_out(pin_a),
        .shared_pin_b_out(pin_b));
    cop_far_side i_cop_far_side_a (.clk_in(clk_in), .clear_in(clear_q),
        .pin_in(pin_a), .edges_out(ea));
    cop_far_side i_cop_far_side_b (.clk_in(clk_in), .clear_in(clear_q),
        .pin_in(pin_b), .edges_out(eb));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic near(input logic [31:0] seen, input logic [31:0] exp);
        check((seen + 1 >= exp && seen <= exp + 1) ? exp : seen, exp);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_q <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_q <= '0;
        #1 check(rdata, exp);
    endtask
    // Settles after an enable change, then counts pin edges for 512 cycles.
    task automatic measure();
        repeat (4) @(posedge clk_in);
        clear_q <= 1'b1;
        @(posedge clk_in);
        clear_q <= 1'b0;
        repeat (512) @(posedge clk_in);
        #1;
    endtask
    task automatic close_out();
        $display("failures=%0d n_checks=%0d", failures, n_checks);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        #1 check({pin_a.oe, pin_b.oe}, 2'h0);
        rd(cop_pkg::DIV_CTRL_ADDR, 8'h00);
        rd(cop_pkg::TMR_A_ADDR, 8'h00);
        rd(cop_pkg::TMR_B_ADDR, 8'h00);
        rd(cop_pkg::FLOAT_ADDR, 8'h03);
        rd(cop_pkg::LEVEL_ADDR, 8'h03);
        rd(16'hff15, 8'h00);
        wr(cop_pkg::FLOAT_ADDR, 8'h02);
        repeat (2) @(posedge clk_in);
        #1 check({pin_a, pin_b.oe}, 3'h6);
        wr(cop_pkg::FLOAT_ADDR, 8'h00);
        for (int n = 0; n < 8; n++) begin
            wr(cop_pkg::DIV_CTRL_ADDR, {1'b1, 3'(n), 1'b1, 3'(n)});
            measure();
            near(eb, 256 >> n);
            near(ea, 512 >> n);
            rd(cop_pkg::DIV_CTRL_ADDR, {1'b1, 3'(n), 1'b1, 3'(n)});
        end
        wr(cop_pkg::TMR_A_ADDR, 8'h08);
        wr(cop_pkg::TMR_B_ADDR, 8'h08);
        measure();
        near(ea, 4);
        near(eb, 2);
        wr(cop_pkg::DIV_CTRL_ADDR, 8'h00);
        measure();
        near(ea, 64);
        near(eb, 128);
        rd(cop_pkg::TMR_A_ADDR, 8'h08);
        wr(cop_pkg::LEVEL_ADDR, 8'h01);
        measure();
        check({eb, pin_b}, 18'h1);
        near(ea, 64);
        // Outputs are stopped; both pins then idle high.
        wr(cop_pkg::TMR_A_ADDR, 8'h00);
        wr(cop_pkg::TMR_B_ADDR, 8'h00);
        wr(cop_pkg::LEVEL_ADDR, 8'h03);
        measure();
        check({ea, pin_a}, 18'h3);
        check({eb, pin_b}, 18'h3);
        close_out();
    end
endmodule
`default_nettype wire

// [sim/cop_far_side.sv]
`default_nettype none
module cop_far_side (
    // Clock and counter clear.
    input wire logic clk_in,
    input wire logic clear_in,
    // Observed pin.
    input wire cop_pkg::cop_pin_t pin_in,
    output logic [15:0] edges_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q;
    // The receiver counts level changes only while the pin is driven.
    always_ff @(posedge clk_in) begin
        last_q <= pin_in.out;
        if (clear_in) begin
            edges_out <= 16'h0;
        end else if (pin_in.oe && pin_in.out !== last_q) begin
            edges_out <= edges_out + 16'h1;
        end
    end
endmodule
`default_nettype wire
